// ===== core/jcc_cfg.svh
// Constants of the character channel: register offsets, field positions, reset values, depths.
// Assumes inclusion by bare name from any file of the channel.
`ifndef JCC_CFG_SVH
`define JCC_CFG_SVH

`define JCC_DATA_OFS 12'h000
`define JCC_CTRL_OFS 12'h004

`define JCC_WFIFO_DEPTH 64
`define JCC_RFIFO_DEPTH 64
`define JCC_WTHRESH 8
`define JCC_RTHRESH 8
`define JCC_USE_REGS 0

`define JCC_CHAR_LSB 0
`define JCC_DATA_VALID_BIT 15
`define JCC_CNT_LSB 16

`define JCC_CTRL_RIE_BIT 0
`define JCC_CTRL_WIE_BIT 1
`define JCC_CTRL_RIP_BIT 8
`define JCC_CTRL_WIP_BIT 9
`define JCC_CTRL_OVF_BIT 10

`define JCC_RIE_RST 1'b0
`define JCC_WIE_RST 1'b0
`define JCC_OVF_RST 1'b0

`endif

// ===== core/jcc_pkg.sv
// Types shared by the character channel files.
// Assumes nothing beyond a SystemVerilog compiler.
package jcc_pkg;

  // One character beat on the link side.
  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } jcc_beat_t;

  // Software control bits.
  typedef struct packed {
    logic ovf;
    logic wie;
    logic rie;
  } jcc_ctrl_t;

endpackage

// ===== core/jcc_mem.sv
// Character storage for one FIFO, written on one clock and read on another.
// Assumes the caller keeps the read address away from entries being written.
`timescale 1ns/10ps
module jcc_mem #(
  parameter int DEPTH = 64,
  parameter int AW = 6,
  parameter bit USE_REGS = 1'b0
) (
  // Write port
  input wire logic wclk,
  input wire logic wen,
  input wire logic [AW-1:0] waddr,
  input wire logic [7:0] wdata,
  // Read port
  input wire logic rclk,
  input wire logic resetn,
  input wire logic [AW-1:0] raddr,
  output logic [7:0] rdata
);

  logic [7:0] mem [DEPTH];

  // Both builds give the same contents; the register build clears on reset.
  generate
    if (USE_REGS) begin : g_regs
      for (genvar i = 0; i < DEPTH; i++) begin : g_ent
        always_ff @(posedge wclk or negedge resetn) begin
          if (!resetn) begin
            mem[i] <= 8'h00;
          end else if (wen && (waddr == AW'(i))) begin
            mem[i] <= wdata;
          end
        end
      end
    end else begin : g_ram
      always_ff @(posedge wclk) begin
        if (wen) begin
          mem[waddr] <= wdata;
        end
      end
    end
  endgenerate

  // Read data always comes out of a register.
  always_ff @(posedge rclk or negedge resetn) begin
    if (!resetn) begin
      rdata <= 8'h00;
    end else begin
      rdata <= mem[raddr];
    end
  end

endmodule

// ===== core/jcc_top.sv
// Character channel between an APB master and a link-side hub node.
// Assumes the hub node runs on link_clock and keeps its own ready/valid rules.
`include "jcc_cfg.svh"
`timescale 1ns/10ps
module jcc_top #(
  parameter int WDEPTH = `JCC_WFIFO_DEPTH,
  parameter int RDEPTH = `JCC_RFIFO_DEPTH,
  parameter int WTHRESH = `JCC_WTHRESH,
  parameter int RTHRESH = `JCC_RTHRESH,
  parameter bit USE_REGS = `JCC_USE_REGS
) (
  // System clock and reset
  input wire logic clock,
  input wire logic resetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Interrupt
  output logic irq,
  // Link side, on its own clock
  input wire logic link_clock,
  output jcc_pkg::jcc_beat_t tx_beat,
  input wire logic tx_ready,
  input wire jcc_pkg::jcc_beat_t rx_beat,
  output logic rx_ready
);

  localparam int WA = $clog2(WDEPTH);
  localparam int RA = $clog2(RDEPTH);

  // Depths outside the documented set stop elaboration.
  generate
    if ((WDEPTH < 8) || (WDEPTH > 32768) || ((1 << WA) != WDEPTH)) begin : g_bad_wdepth
      $error("write FIFO depth must be a power of two from 8 to 32768");
    end
    if ((RDEPTH < 8) || (RDEPTH > 32768) || ((1 << RA) != RDEPTH)) begin : g_bad_rdepth
      $error("read FIFO depth must be a power of two from 8 to 32768");
    end
  endgenerate

  // State of the system clock domain.
  typedef struct packed {
    logic [WA:0] wf_wbin;
    logic [WA:0] wf_wgray;
    logic [WA:0] wf_rg1;
    logic [WA:0] wf_rg2;
    logic [RA:0] rf_rbin;
    logic [RA:0] rf_rgray;
    logic [RA:0] rf_wg1;
    logic [RA:0] rf_wg2;
    jcc_pkg::jcc_ctrl_t ctrl;
    logic irq;
    logic [31:0] prdata;
  } jcc_sys_t;

  // State of the link clock domain.
  typedef struct packed {
    logic [1:0] rst;
    logic [WA:0] wf_rbin;
    logic [WA:0] wf_rgray;
    logic [WA:0] wf_wg1;
    logic [WA:0] wf_wg2;
    logic [RA:0] rf_wbin;
    logic [RA:0] rf_wgray;
    logic [RA:0] rf_rg1;
    logic [RA:0] rf_rg2;
  } jcc_link_t;

  jcc_sys_t s_q;
  jcc_sys_t s_d;
  jcc_link_t l_q;
  jcc_link_t l_d;

  logic [RA:0] rf_rgray;
  logic [7:0] wf_q;
  logic [7:0] rf_q;
  logic wf_push;
  logic rf_push;

  // Binary to gray and back on the widest pointer.
  function automatic logic [15:0] b2g(input logic [15:0] b);
    b2g = b ^ (b >> 1);
  endfunction

  function automatic logic [15:0] g2b(input logic [15:0] g);
    logic [15:0] b;
    b = 16'h0000;
    b[15] = g[15];
    for (int i = 14; i >= 0; i--) begin
      b[i] = b[i + 1] ^ g[i];
    end
    g2b = b;
  endfunction

  // ---------------- System domain ----------------

  logic access;
  logic setup;
  logic hit_data;
  logic hit_ctrl;
  logic [WA:0] wf_cnt;
  logic [WA:0] wf_space;
  logic wf_full;
  logic [RA:0] rf_cnt;
  logic [RA:0] rf_space;
  logic rf_avail;
  logic wip;
  logic rip;
  logic rf_pop;
  logic [31:0] rd_val;

  assign rf_rgray = s_q.rf_rgray;

  always_comb begin
    s_d = s_q;
    access = psel && penable;
    setup = psel && !penable;
    hit_data = (paddr == `JCC_DATA_OFS);
    hit_ctrl = (paddr == `JCC_CTRL_OFS);
    // Pointer synchronisers: first stage feeds only the second.
    s_d.wf_rg1 = l_q.wf_rgray;
    s_d.wf_rg2 = s_q.wf_rg1;
    s_d.rf_wg1 = l_q.rf_wgray;
    s_d.rf_wg2 = s_q.rf_wg1;
    // Fill levels as seen from the bus side.
    wf_cnt = s_q.wf_wbin - (WA+1)'(g2b(16'(s_q.wf_rg2)));
    wf_space = (WA+1)'(WDEPTH) - wf_cnt;
    wf_full = (wf_cnt == (WA+1)'(WDEPTH));
    rf_cnt = (RA+1)'(g2b(16'(s_q.rf_wg2))) - s_q.rf_rbin;
    rf_space = (RA+1)'(RDEPTH) - rf_cnt;
    rf_avail = (rf_cnt != '0);
    // Threshold conditions behind the interrupt.
    wip = (wf_cnt <= (WA+1)'(WTHRESH));
    rip = (rf_space <= (RA+1)'(RTHRESH)) && rf_avail;
    // Read value captured in the setup cycle.
    rd_val = 32'h0000_0000;
    if (hit_data) begin
      rd_val[`JCC_CHAR_LSB +: 8] = rf_q;
      rd_val[`JCC_DATA_VALID_BIT] = rf_avail;
      rd_val[`JCC_CNT_LSB +: 16] = 16'(rf_cnt);
    end else if (hit_ctrl) begin
      rd_val[`JCC_CTRL_RIE_BIT] = s_q.ctrl.rie;
      rd_val[`JCC_CTRL_WIE_BIT] = s_q.ctrl.wie;
      rd_val[`JCC_CTRL_RIP_BIT] = rip;
      rd_val[`JCC_CTRL_WIP_BIT] = wip;
      rd_val[`JCC_CTRL_OVF_BIT] = s_q.ctrl.ovf;
      rd_val[`JCC_CNT_LSB +: 16] = 16'(wf_space);
    end
    if (setup) begin
      s_d.prdata = rd_val;
    end
    // Write FIFO push; a write to a full FIFO is dropped and flagged.
    wf_push = access && pwrite && hit_data && !wf_full;
    if (wf_push) begin
      s_d.wf_wbin = s_q.wf_wbin + (WA+1)'(1);
    end
    s_d.wf_wgray = (WA+1)'(b2g(16'(s_d.wf_wbin)));
    // Read FIFO pop only when the captured value showed a character.
    rf_pop = access && !pwrite && hit_data && s_q.prdata[`JCC_DATA_VALID_BIT];
    if (rf_pop) begin
      s_d.rf_rbin = s_q.rf_rbin + (RA+1)'(1);
    end
    // The gray pointer is registered so the link side never samples a glitch.
    s_d.rf_rgray = (RA+1)'(b2g(16'(s_d.rf_rbin)));
    // Control writes; a new overflow wins over its clear.
    if (access && pwrite && hit_ctrl) begin
      s_d.ctrl.rie = pwdata[`JCC_CTRL_RIE_BIT];
      s_d.ctrl.wie = pwdata[`JCC_CTRL_WIE_BIT];
      if (pwdata[`JCC_CTRL_OVF_BIT]) begin
        s_d.ctrl.ovf = 1'b0;
      end
    end
    if (access && pwrite && hit_data && wf_full) begin
      s_d.ctrl.ovf = 1'b1;
    end
    // Interrupt level from enabled conditions.
    s_d.irq = (s_q.ctrl.rie && rip) || (s_q.ctrl.wie && wip);
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      s_q <= '0;
      s_q.ctrl.rie <= `JCC_RIE_RST;
      s_q.ctrl.wie <= `JCC_WIE_RST;
      s_q.ctrl.ovf <= `JCC_OVF_RST;
    end else begin
      s_q <= s_d;
    end
  end

  assign prdata = s_q.prdata;
  assign pready = psel && penable;
  assign pslverr = psel && penable && !(hit_data || hit_ctrl);
  assign irq = s_q.irq;

  // ---------------- Link domain ----------------

  logic l_run;
  logic wf_empty_l;
  logic rf_full_l;
  logic [RA:0] rf_cnt_l;
  logic tx_take;

  always_comb begin
    l_d = l_q;
    // Reset release is carried into the link domain by two stages.
    l_d.rst = {l_q.rst[0], 1'b1};
    l_run = l_q.rst[1];
    l_d.wf_wg1 = s_q.wf_wgray;
    l_d.wf_wg2 = l_q.wf_wg1;
    l_d.rf_rg1 = rf_rgray;
    l_d.rf_rg2 = l_q.rf_rg1;
    wf_empty_l = (l_q.wf_rbin == (WA+1)'(g2b(16'(l_q.wf_wg2))));
    rf_cnt_l = l_q.rf_wbin - (RA+1)'(g2b(16'(l_q.rf_rg2)));
    rf_full_l = (rf_cnt_l == (RA+1)'(RDEPTH));
    // Offer only from a non-empty write FIFO; take only into a non-full read FIFO.
    tx_take = l_run && !wf_empty_l && tx_ready;
    rf_push = l_run && !rf_full_l && rx_beat.valid;
    if (tx_take) begin
      l_d.wf_rbin = l_q.wf_rbin + (WA+1)'(1);
    end
    if (rf_push) begin
      l_d.rf_wbin = l_q.rf_wbin + (RA+1)'(1);
    end
    l_d.wf_rgray = (WA+1)'(b2g(16'(l_d.wf_rbin)));
    l_d.rf_wgray = (RA+1)'(b2g(16'(l_d.rf_wbin)));
  end

  always_ff @(posedge link_clock or negedge resetn) begin
    if (!resetn) begin
      l_q <= '0;
    end else begin
      l_q <= l_d;
    end
  end

  assign tx_beat.valid = l_run && !wf_empty_l;
  assign tx_beat.data = wf_q;
  assign rx_ready = l_run && !rf_full_l;

  // ---------------- Storage, one per direction ----------------

  // Bus to link.
  jcc_mem #(
    .DEPTH(WDEPTH),
    .AW(WA),
    .USE_REGS(USE_REGS)
  ) u_wfifo (
    .wclk(clock),
    .wen(wf_push),
    .waddr(s_q.wf_wbin[WA-1:0]),
    .wdata(pwdata[`JCC_CHAR_LSB +: 8]),
    .rclk(link_clock),
    .resetn(resetn),
    .raddr(l_d.wf_rbin[WA-1:0]),
    .rdata(wf_q)
  );

  // Link to bus.
  jcc_mem #(
    .DEPTH(RDEPTH),
    .AW(RA),
    .USE_REGS(USE_REGS)
  ) u_rfifo (
    .wclk(link_clock),
    .wen(rf_push),
    .waddr(l_q.rf_wbin[RA-1:0]),
    .wdata(rx_beat.data),
    .rclk(clock),
    .resetn(resetn),
    .raddr(s_d.rf_rbin[RA-1:0]),
    .rdata(rf_q)
  );

endmodule

// ===== test/jcc_asserts.sv
// Concurrent checks on the port signals of the character channel.
// Assumes binding to jcc_top; bus checks on clock, link checks on link_clock.
`timescale 1ns/10ps
module jcc_checker (
  // Clocks and reset
  input wire logic clock,
  input wire logic link_clock,
  input wire logic resetn,
  // Bus
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic irq,
  // Link
  input wire jcc_pkg::jcc_beat_t tx_beat,
  input wire logic tx_ready,
  input wire logic rx_ready
);
  logic acc;
  logic hit;
  assign acc = psel && penable;
  assign hit = (paddr == 12'h000) || (paddr == 12'h004);
  chk_ready_access: assert property (@(posedge clock) disable iff (!resetn) acc |-> pready)
    else $error("pready low in access cycle");
  chk_err_unmapped: assert property (@(posedge clock) disable iff (!resetn) acc && !hit |-> pslverr)
    else $error("unmapped access not refused");
  chk_err_mapped: assert property (@(posedge clock) disable iff (!resetn) acc && hit |-> !pslverr)
    else $error("mapped access refused");
  chk_err_idle: assert property (@(posedge clock) disable iff (!resetn) !acc |-> !pslverr)
    else $error("pslverr outside access");
  chk_rdata_zero: assert property (@(posedge clock) disable iff (!resetn)
    acc && !hit && !pwrite |-> prdata == 32'h0000_0000) else $error("unmapped read not zero");
  chk_irq_reset: assert property (@(posedge clock) disable iff (!resetn) $rose(resetn) |-> !irq)
    else $error("irq high after reset");
  chk_tx_hold: assert property (@(posedge link_clock) disable iff (!resetn)
    tx_beat.valid && !tx_ready |=> tx_beat.valid && $stable(tx_beat.data))
    else $error("tx character dropped before taken");
  chk_link_reset: assert property (@(posedge link_clock) disable iff (!resetn)
    $rose(resetn) |-> !rx_ready && !tx_beat.valid) else $error("link active at reset exit");
endmodule

bind jcc_top jcc_checker u_chk (
  .clock(clock), .link_clock(link_clock), .resetn(resetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .irq(irq), .tx_beat(tx_beat), .tx_ready(tx_ready), .rx_ready(rx_ready)
);

// ===== test/jcc_hub.sv
// Link-side hub model: collects outgoing characters and sends incoming ones.
// Assumes the bench drives hold and calls send from its main sequence.
`timescale 1ns/10ps
module jcc_hub (
  // Link clock and reset
  input wire logic link_clock,
  input wire logic resetn,
  // Characters from the channel
  input wire jcc_pkg::jcc_beat_t tx_beat,
  output logic tx_ready,
  // Characters to the channel
  output jcc_pkg::jcc_beat_t rx_beat,
  input wire logic rx_ready,
  // Stall control
  input wire logic hold
);
  logic [7:0] got[$];
  assign tx_ready = !hold;
  initial rx_beat = '{valid: 1'b0, data: 8'hA5};
  always @(posedge link_clock) begin
    if (resetn && tx_beat.valid && tx_ready) begin
      got.push_back(tx_beat.data);
    end
  end
  task automatic send(input logic [7:0] c);
    @(posedge link_clock);
    rx_beat <= '{valid: 1'b1, data: c};
    do @(posedge link_clock); while (rx_ready !== 1'b1);
    rx_beat <= '{valid: 1'b0, data: ~c};
  endtask
endmodule

// ===== test/tb_jtag_character_channel.sv
// Self-checking bench of the character channel with a bus master and a hub model.
// Assumes the design files and the checker are compiled before this file.
`include "jcc_cfg.svh"
`timescale 1ns/10ps
`define CHK(a, b, m) begin \
  total_checks++; \
  if ((a) !== (b)) begin \
    bad_count++; \
    $display("MISMATCH %0t %s", $time, m); \
  end end
module tb_jtag_character_channel;
  logic clock, link_clock, resetn, psel, penable, pwrite, hold, pready, pslverr, irq;
  logic tx_ready, rx_ready, re;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rq;
  jcc_pkg::jcc_beat_t tx_beat, rx_beat;
  int bad_count, total_checks, i, n;
  jcc_top #(.WDEPTH(8), .RDEPTH(8), .WTHRESH(2), .RTHRESH(2), .USE_REGS(1'b0)) dut (
    .clock(clock), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .irq(irq), .link_clock(link_clock), .tx_beat(tx_beat), .tx_ready(tx_ready),
    .rx_beat(rx_beat), .rx_ready(rx_ready));
  jcc_hub hub (.link_clock(link_clock), .resetn(resetn), .tx_beat(tx_beat),
    .tx_ready(tx_ready), .rx_beat(rx_beat), .rx_ready(rx_ready), .hold(hold));
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end
  initial begin
    link_clock = 1'b0;
    #7;
    forever #24 link_clock = ~link_clock;
  end
  // One bus master only, so both character streams stay in order.
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do @(posedge clock); while (pready !== 1'b1);
    rq = prdata;
    re = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] x, input logic e);
    apb(1'b0, a, 32'h0000_0000);
    `CHK(rq, x, "read data")
    `CHK(re, e, "read response")
  endtask
  task automatic wait_irq(input logic v);
    for (n = 0; n < 300 && irq !== v; n++) @(posedge clock);
    `CHK(irq, v, "irq level")
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  initial begin
    #400000;
    bad_count++;
    $display("MISMATCH %0t watchdog expired", $time);
    final_report();
  end
  initial begin
    {resetn, psel, penable, pwrite, hold} = 5'h00;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    repeat (2) @(posedge clock);
    resetn <= 1'b1;
    rd(`JCC_CTRL_OFS, 32'h0008_0200, 1'b0);
    rd(12'h008, 32'h0000_0000, 1'b1);
    apb(1'b1, `JCC_CTRL_OFS, 32'h0000_0002);
    wait_irq(1'b1);
    $display("test registers done");
    hold <= 1'b1;
    for (i = 0; i < 9; i++) apb(1'b1, `JCC_DATA_OFS, 32'hABCD_EF00 | (8'h41 + i));
    rd(`JCC_CTRL_OFS, 32'h0000_0402, 1'b0);
    wait_irq(1'b0);
    hold <= 1'b0;
    for (n = 0; n < 300 && hub.got.size() < 8; n++) @(posedge clock);
    `CHK(hub.got.size(), 8, "drained count")
    for (i = 0; i < 8 && i < hub.got.size(); i++) `CHK(hub.got[i], 8'(8'h41 + i), "tx char")
    wait_irq(1'b1);
    hold <= 1'b1;
    for (i = 0; i < 2; i++) apb(1'b1, `JCC_DATA_OFS, 32'h0000_0050 + i);
    rd(`JCC_CTRL_OFS, 32'h0006_0602, 1'b0);
    wait_irq(1'b1);
    for (i = 2; i < 4; i++) apb(1'b1, `JCC_DATA_OFS, 32'h0000_0050 + i);
    rd(`JCC_CTRL_OFS, 32'h0004_0402, 1'b0);
    wait_irq(1'b0);
    hold <= 1'b0;
    for (n = 0; n < 300 && hub.got.size() < 12; n++) @(posedge clock);
    `CHK(hub.got.size(), 12, "refill count")
    for (i = 8; i < 12 && i < hub.got.size(); i++) `CHK(hub.got[i], 8'(8'h48 + i), "refill char")
    wait_irq(1'b1);
    $display("test write direction done");
    apb(1'b1, `JCC_CTRL_OFS, 32'h0000_0400);
    rd(`JCC_CTRL_OFS, 32'h0008_0200, 1'b0);
    apb(1'b1, `JCC_CTRL_OFS, 32'h0000_0001);
    wait_irq(1'b0);
    for (i = 0; i < 8; i++) hub.send(8'(8'hC0 + i));
    wait_irq(1'b1);
    rd(`JCC_CTRL_OFS, 32'h0008_0301, 1'b0);
    for (i = 0; i < 8; i++) rd(`JCC_DATA_OFS, {16'(8 - i), 8'h80, 8'(8'hC0 + i)}, 1'b0);
    rd(`JCC_CTRL_OFS, 32'h0008_0201, 1'b0);
    apb(1'b0, `JCC_DATA_OFS, 32'h0000_0000);
    `CHK(rq[15], 1'b0, "empty read valid")
    wait_irq(1'b0);
    $display("test read direction done");
    final_report();
  end
endmodule
